// ===== inc/tisc_map.svh
`ifndef TISC_MAP_SVH
`define TISC_MAP_SVH

// register indexes; the byte address is four times the index
`define TISC_IDX_W          10
`define TISC_IDX_IRQ_CTRL   10'h1E3
`define TISC_IDX_MASK       10'h1E4
`define TISC_IDX_STATUS     10'h1E5
`define TISC_IDX_CLK_CTRL   10'h1E6
`define TISC_IDX_CNT0       10'h040
`define TISC_IDX_CNT1       10'h041
`define TISC_IDX_CNT2       10'h042
`define TISC_IDX_CMD        10'h043

// event status / mask layout
`define TISC_EVT_W          5
`define TISC_BIT_PARITY     4
`define TISC_BIT_SYSERR     3
`define TISC_STATUS_RST     5'h00
`define TISC_MASK_RST       5'h00

// interrupt control layout
`define TISC_BIT_GLOBAL_EN  4
`define TISC_IRQ_CTRL_RST   5'h00

// counter clocking control layout
`define TISC_BIT_GATE2      7
`define TISC_BIT_GATE1      6
`define TISC_BIT_GATE0      5
`define TISC_BIT_CHAIN      4
`define TISC_BIT_SRC1       3
`define TISC_BIT_SRC0       2
`define TISC_CLK_CTRL_RST   6'h00

// internal counter clock divider
`define TISC_INT_DIV        8

// pin synchroniser reset level: error lines idle high, clocks low
`define TISC_SYNC_RST       4'hC

`endif

// ===== inc/tisc_pkg.sv
package tisc_pkg;

    // counter operating modes of the command word
    typedef enum logic [2:0] {
        TISC_M_TERM,
        TISC_M_ONESHOT,
        TISC_M_RATE,
        TISC_M_SQUARE,
        TISC_M_SW_STROBE,
        TISC_M_HW_STROBE
    } tisc_mode_t;

    // byte access selection of the command word
    typedef enum logic [1:0] {
        TISC_RW_LATCH,
        TISC_RW_LSB,
        TISC_RW_MSB,
        TISC_RW_BOTH
    } tisc_rw_t;

    typedef logic [15:0] tisc_count_t;
    typedef logic [7:0]  tisc_byte_t;

endpackage : tisc_pkg

// ===== rtl/tisc_top.sv
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/1ps
`include "tisc_map.svh"
// How it works
// - status flags: parity error bit 4, system error bit 3, counters bits 2..0
// - writing one to a status flag clears it; zero leaves it
// - flags set and readable whatever the mask holds
// - counter flags set on output rising edge only, sticky until cleared
// - block watches both bus error lines and flags any assertion held for two or more cycles
// - control bits 7..5 set gate levels of counters 2..0
// - control bit 4 low chains counters 1 and 2, high separates
// - control bit 3 picks counter 1 clock: external or internal
// - control bit 2 picks counter 0 clock: external or internal
// - internal counter clock is the bus clock divided by eight
// - three 16-bit binary counters; decimal bit stored but ignored
// - chained: counter 1 low half, its output clocks counter 2
// - counter 2 counts internal clock unless chained
// - counters keep the standard interval timer programming model
// - interrupt raised only for flags whose mask bit is one
// - global enable bit 4 of interrupt control gates the output
module tisc_top
    import tisc_pkg::*;
#(
    parameter int DIV = `TISC_INT_DIV
) (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [11:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // pins
    input  wire logic        ext_clock_in_0,
    input  wire logic        ext_clock_in_1,
    input  wire logic        parity_err_n,
    input  wire logic        system_err_n,
    // results
    output logic      [2:0]  counter_out,
    output logic             irq
);
    import tisc_pkg::*;

    // index match, used by every strobe below
    function automatic logic idx_hit(input logic [11:0] a, input logic [`TISC_IDX_W-1:0] idx);
        idx_hit = (a[11:2] == idx) && (a[1:0] == 2'b00);
    endfunction : idx_hit

    // ---------------- bus slave ----------------
    logic        ap_valid_ff;
    logic        ap_write_ff;
    logic [11:0] ap_addr_ff;
    logic [31:0] hrdata_ff;
    logic        hreadyout_ff;

    wire logic take   = hsel & htrans[1] & hready;
    wire logic wr_go  = ap_valid_ff & ap_write_ff;
    wire logic rd_go  = ap_valid_ff & ~ap_write_ff;
    wire logic [7:0] wbyte = hwdata[7:0];

    // every transfer gets one wait state, so a read always sees the write before it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_valid_ff  <= 1'b0;
            ap_write_ff  <= 1'b0;
            ap_addr_ff   <= 12'h000;
            hreadyout_ff <= 1'b1;
        end else begin
            ap_valid_ff  <= take;
            ap_write_ff  <= take & hwrite;
            ap_addr_ff   <= take ? haddr : ap_addr_ff;
            hreadyout_ff <= ~take;
        end
    end

    // register strobes of the data phase
    wire logic sel_irqc   = idx_hit(ap_addr_ff, `TISC_IDX_IRQ_CTRL);
    wire logic sel_mask   = idx_hit(ap_addr_ff, `TISC_IDX_MASK);
    wire logic sel_stat   = idx_hit(ap_addr_ff, `TISC_IDX_STATUS);
    wire logic sel_clkc   = idx_hit(ap_addr_ff, `TISC_IDX_CLK_CTRL);
    wire logic sel_cmd    = idx_hit(ap_addr_ff, `TISC_IDX_CMD);
    wire logic [2:0] sel_cnt = {idx_hit(ap_addr_ff, `TISC_IDX_CNT2),
                                idx_hit(ap_addr_ff, `TISC_IDX_CNT1),
                                idx_hit(ap_addr_ff, `TISC_IDX_CNT0)};

    // ---------------- software registers ----------------
    logic [`TISC_EVT_W-1:0] irq_ctrl_ff;
    logic [`TISC_EVT_W-1:0] mask_ff;
    logic [`TISC_EVT_W-1:0] status_ff;
    logic [5:0]             clk_ctrl_ff;   // holds control bits 7..2

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_ctrl_ff <= `TISC_IRQ_CTRL_RST;
            mask_ff     <= `TISC_MASK_RST;
            clk_ctrl_ff <= `TISC_CLK_CTRL_RST;
        end else begin
            if (wr_go && sel_irqc)
                irq_ctrl_ff <= wbyte[4:0];
            if (wr_go && sel_mask)
                mask_ff <= wbyte[4:0];
            // reserved bits 1..0 are dropped, so a stray one is harmless
            // reserved bits ignored
            if (wr_go && sel_clkc)
                clk_ctrl_ff <= wbyte[7:2];
        end
    end

    // control fields
    // gate levels from control
    wire logic [2:0] gate_lvl = {clk_ctrl_ff[`TISC_BIT_GATE2-2],
                                 clk_ctrl_ff[`TISC_BIT_GATE1-2],
                                 clk_ctrl_ff[`TISC_BIT_GATE0-2]};
    wire logic chained   = ~clk_ctrl_ff[`TISC_BIT_CHAIN-2];
    wire logic src1_int  = clk_ctrl_ff[`TISC_BIT_SRC1-2];
    wire logic src0_int  = clk_ctrl_ff[`TISC_BIT_SRC0-2];

    // ---------------- pin synchronisers ----------------
    // bits: 0 ext clock 0, 1 ext clock 1, 2 parity error, 3 system error
    logic [3:0] sync1_ff;
    logic [3:0] sync2_ff;
    logic [3:0] sync3_ff;
    logic [3:0] filt_ff;
    logic [3:0] filt_prev_ff;

    // a level is accepted only once the second and third stages agree
    // three-stage pin sync
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_ff     <= `TISC_SYNC_RST;
            sync2_ff     <= `TISC_SYNC_RST;
            sync3_ff     <= `TISC_SYNC_RST;
            filt_ff      <= `TISC_SYNC_RST;
            filt_prev_ff <= `TISC_SYNC_RST;
        end else begin
            sync1_ff     <= {system_err_n, parity_err_n, ext_clock_in_1, ext_clock_in_0};
            sync2_ff     <= sync1_ff;
            sync3_ff     <= sync2_ff;
            filt_ff      <= (sync2_ff & sync3_ff) | (filt_ff & (sync2_ff | sync3_ff));
            filt_prev_ff <= filt_ff;
        end
    end

    wire logic [1:0] ext_rise = filt_ff[1:0] & ~filt_prev_ff[1:0];

    // ---------------- internal divided clock ----------------
    logic [$clog2(DIV)-1:0] div_ff;
    wire logic int_tick = (div_ff == $clog2(DIV)'(DIV - 1));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            div_ff <= '0;
        else
            div_ff <= int_tick ? '0 : div_ff + 1'b1;
    end

    // ---------------- counter clocks ----------------
    logic [2:0] out_prev_ff;
    wire logic [2:0] cnt_out;
    wire logic [2:0] out_rise = cnt_out & ~out_prev_ff;
    wire logic [2:0] tick;

    assign tick[0] = src0_int ? int_tick : ext_rise[0];
    assign tick[1] = src1_int ? int_tick : ext_rise[1];
    // when chained, counter 1 output clocks counter 2
    assign tick[2] = chained ? out_rise[1] : int_tick;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            out_prev_ff <= 3'h0;
        else
            out_prev_ff <= cnt_out;
    end

    // ---------------- the three counters ----------------
    wire tisc_byte_t rd_byte [3];
    wire logic [1:0] cmd_sel = wbyte[7:6];

    for (genvar i = 0; i < 3; i++) begin : g_cnt
        tisc_count_t cnt_ff;
        tisc_count_t reload_ff;
        tisc_count_t latch_ff;
        tisc_mode_t  mode_ff;
        tisc_rw_t    rw_ff;
        logic        bcd_ff;       // stored only, never read back or used to count
        logic        out_ff;
        logic        armed_ff;
        logic        load_pend_ff;
        logic        trig_ff;
        logic        gate_prev_ff;
        logic        latched_ff;
        logic        wr_hi_ff;
        logic        rd_hi_ff;

        wire logic cmd_wr   = wr_go & sel_cmd & (cmd_sel == 2'(i));
        wire logic data_wr  = wr_go & sel_cnt[i];
        wire logic data_rd  = rd_go & sel_cnt[i];
        wire logic hw_trig  = (mode_ff == TISC_M_ONESHOT) || (mode_ff == TISC_M_HW_STROBE);
        wire logic periodic = (mode_ff == TISC_M_RATE) || (mode_ff == TISC_M_SQUARE);
        wire logic run      = armed_ff & (gate_lvl[i] | hw_trig);
        wire logic last_wr  = (rw_ff != TISC_RW_BOTH) | wr_hi_ff;
        // codes 6 and 7 alias modes 2 and 3; modes 4 and 5 pass unchanged
        wire logic [2:0] cmd_mode = (wbyte[3:2] == 2'b11) ? {1'b0, wbyte[2:1]} : wbyte[3:1];
        wire tisc_count_t shown = latched_ff ? latch_ff : cnt_ff;
        wire logic read_hi  = (rw_ff == TISC_RW_MSB) | ((rw_ff == TISC_RW_BOTH) & rd_hi_ff);

        assign rd_byte[i] = read_hi ? shown[15:8] : shown[7:0];
        assign cnt_out[i] = out_ff;

        // bus side: command word, count load, latch and byte pointers
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                reload_ff  <= 16'h0000;
                latch_ff   <= 16'h0000;
                mode_ff    <= TISC_M_TERM;
                rw_ff      <= TISC_RW_LSB;
                bcd_ff     <= 1'b0;
                latched_ff <= 1'b0;
                wr_hi_ff   <= 1'b0;
                rd_hi_ff   <= 1'b0;
            end else if (cmd_wr && wbyte[5:4] == 2'h0) begin
                // a second latch before the first is read is ignored
                latched_ff <= 1'b1;
                latch_ff   <= latched_ff ? latch_ff : cnt_ff;
            end else if (cmd_wr) begin
                mode_ff    <= tisc_mode_t'(cmd_mode);
                rw_ff      <= tisc_rw_t'(wbyte[5:4]);
                bcd_ff     <= wbyte[0];
                latched_ff <= 1'b0;
                wr_hi_ff   <= 1'b0;
                rd_hi_ff   <= 1'b0;
            end else if (data_wr) begin
                if (rw_ff == TISC_RW_MSB || (rw_ff == TISC_RW_BOTH && wr_hi_ff))
                    reload_ff[15:8] <= wbyte;
                else
                    reload_ff[7:0] <= wbyte;
                if (rw_ff == TISC_RW_LSB)
                    reload_ff[15:8] <= 8'h00;
                if (rw_ff == TISC_RW_MSB)
                    reload_ff[7:0] <= 8'h00;
                wr_hi_ff <= (rw_ff == TISC_RW_BOTH) & ~wr_hi_ff;
            end else if (data_rd) begin
                rd_hi_ff <= (rw_ff == TISC_RW_BOTH) & ~rd_hi_ff;
                // the latch releases once every byte of it has been read
                if (rw_ff != TISC_RW_BOTH || rd_hi_ff)
                    latched_ff <= 1'b0;
            end
        end

        // counting side; a zero reload counts the full 65536 range, except in square mode where it toggles every tick
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                cnt_ff       <= 16'h0000;
                out_ff       <= 1'b0;
                armed_ff     <= 1'b0;
                load_pend_ff <= 1'b0;
                trig_ff      <= 1'b0;
                gate_prev_ff <= 1'b0;
            end else begin
                gate_prev_ff <= gate_lvl[i];
                if (gate_lvl[i] && !gate_prev_ff)
                    trig_ff <= 1'b1;
                if (cmd_wr && wbyte[5:4] != 2'h0) begin
                    out_ff       <= (cmd_mode != 3'(TISC_M_TERM));
                    armed_ff     <= 1'b0;
                    load_pend_ff <= 1'b0;
                    trig_ff      <= 1'b0;
                end else if (data_wr && last_wr) begin
                    load_pend_ff <= 1'b1;
                    if (mode_ff == TISC_M_TERM)
                        out_ff <= 1'b0;
                end else if (periodic && !gate_lvl[i]) begin
                    // periodic modes hold the output high while gated off
                    out_ff <= 1'b1;
                end else if (tick[i]) begin
                    if (hw_trig && trig_ff && (load_pend_ff || armed_ff)) begin
                        cnt_ff       <= reload_ff;
                        armed_ff     <= 1'b1;
                        load_pend_ff <= 1'b0;
                        trig_ff      <= 1'b0;
                        out_ff       <= (mode_ff != TISC_M_ONESHOT);
                    end else if (!hw_trig && load_pend_ff && (gate_lvl[i] || !periodic)) begin
                        cnt_ff       <= reload_ff;
                        armed_ff     <= 1'b1;
                        load_pend_ff <= 1'b0;
                    end else if (run) begin
                        case (mode_ff)
                            TISC_M_TERM, TISC_M_ONESHOT: begin
                                cnt_ff <= cnt_ff - 16'h0001;
                                if (cnt_ff == 16'h0001)
                                    out_ff <= 1'b1;
                            end
                            TISC_M_RATE: begin
                                out_ff <= (cnt_ff != 16'h0002);
                                cnt_ff <= (cnt_ff == 16'h0001) ? reload_ff : cnt_ff - 16'h0001;
                            end
                            TISC_M_SQUARE: begin
                                if (cnt_ff[15:1] == 15'h0001 || cnt_ff[15:1] == 15'h0000) begin
                                    cnt_ff <= reload_ff;
                                    out_ff <= ~out_ff;
                                end else begin
                                    cnt_ff <= cnt_ff - 16'h0002;
                                end
                            end
                            TISC_M_SW_STROBE, TISC_M_HW_STROBE: begin
                                // one strobe, then the counter stops until reloaded
                                cnt_ff <= cnt_ff - 16'h0001;
                                out_ff <= (cnt_ff != 16'h0001);
                                if (cnt_ff == 16'h0001)
                                    armed_ff <= 1'b0;
                            end
                            default: begin
                                cnt_ff <= cnt_ff;
                            end
                        endcase
                    end else if (!out_ff && !periodic && mode_ff != TISC_M_TERM && !armed_ff) begin
                        // end of a strobe: return high one tick later
                        out_ff <= (mode_ff != TISC_M_ONESHOT);
                    end
                end
            end
        end
    end

    // ---------------- event status ----------------
    // error lines watched here
    wire logic [`TISC_EVT_W-1:0] evt_set = {~filt_ff[2], ~filt_ff[3], out_rise};
    wire logic [`TISC_EVT_W-1:0] evt_clr = (wr_go && sel_stat) ? wbyte[4:0] : 5'h00;

    // a new event in the clearing cycle survives because the set is applied last
    // sticky flags, set wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            status_ff <= `TISC_STATUS_RST;
        else
            status_ff <= (status_ff & ~evt_clr) | evt_set;
    end

    // ---------------- interrupt ----------------
    // low nibble of interrupt control must stay zero for the request to pass
    // masked flags only
    wire logic nxt_irq = irq_ctrl_ff[`TISC_BIT_GLOBAL_EN] & (irq_ctrl_ff[3:0] == 4'h0)
                         & (|(status_ff & mask_ff));

    logic irq_ff;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            irq_ff <= 1'b0;
        else
            irq_ff <= nxt_irq;
    end

    // ---------------- read data ----------------
    // unmapped words read as zero and writes to them are dropped
    wire logic [7:0] rd_mux =
        sel_irqc   ? {3'h0, irq_ctrl_ff} :
        sel_mask   ? {3'h0, mask_ff} :
        sel_stat   ? {3'h0, status_ff} :
        sel_clkc   ? {clk_ctrl_ff, 2'h0} :
        sel_cnt[0] ? rd_byte[0] :
        sel_cnt[1] ? rd_byte[1] :
        sel_cnt[2] ? rd_byte[2] : 8'h00;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            hrdata_ff <= 32'h00000000;
        else if (rd_go)
            hrdata_ff <= {24'h000000, rd_mux};
    end

    // outputs
    assign hrdata      = hrdata_ff;
    assign hreadyout   = hreadyout_ff;
    assign hresp       = 1'b0;   // always OKAY
    assign counter_out = out_prev_ff;
    assign irq         = irq_ff;

endmodule : tisc_top

// ===== testbench/tisc_top_monitor.sv
`timescale 1ns/1ps
`include "tisc_map.svh"
module tisc_chk (
    // clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // bus
    input wire logic        hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    // pins and results
    input wire logic        parity_err_n,
    input wire logic        system_err_n,
    input wire logic [2:0]  counter_out,
    input wire logic        irq
);
    localparam logic [11:0] A_EN = {`TISC_IDX_IRQ_CTRL, 2'h0};
    localparam logic [11:0] A_MK = {`TISC_IDX_MASK, 2'h0};
    logic        wr_ff;
    logic [11:0] adr_ff;
    logic [4:0]  en_ff;
    logic [4:0]  mask_ff;
    wire         taken = hsel && htrans[1] && hready;
    wire         en_ok = en_ff[4] && (en_ff[3:0] == 4'h0);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // shadow of the gating registers; irq can only be judged against what software wrote
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ff <= 1'b0;
            adr_ff <= 12'h000;
            en_ff <= 5'h00;
            mask_ff <= 5'h00;
        end else begin
            wr_ff <= taken && hwrite;
            if (taken) adr_ff <= haddr;
            if (wr_ff && adr_ff == A_EN) en_ff <= hwdata[4:0];
            if (wr_ff && adr_ff == A_MK) mask_ff <= hwdata[4:0];
        end
    end
    AST_WAIT: assert property (taken |=> !hreadyout ##1 hreadyout)
        else $error("transfer wait state wrong");
    AST_RDHI: assert property (hrdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    AST_MASK: assert property (mask_ff == 5'h00 |=> !irq)
        else $error("irq with all masked");
    AST_ROSE: assert property ($rose(irq) |-> $past(en_ok) && ($past(mask_ff) != 5'h00))
        else $error("irq rose without enable");
    AST_GATE: assert property (!en_ok |=> !irq)
        else $error("irq while disabled");
    AST_PERR: assert property ((!parity_err_n) [*3] ##0 (mask_ff[4] && en_ok) |-> ##[1:8] irq)
        else $error("parity error missed");
    AST_SERR: assert property ((!system_err_n) [*3] ##0 (mask_ff[3] && en_ok) |-> ##[1:8] irq)
        else $error("system error missed");
    AST_CNT: assert property ($rose(counter_out[0]) && mask_ff[0] && en_ok |-> ##[0:3] irq)
        else $error("counter edge missed");
endmodule : tisc_chk

bind tisc_top tisc_chk tisc_chk_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .parity_err_n(parity_err_n), .system_err_n(system_err_n),
    .counter_out(counter_out), .irq(irq));

// ===== testbench/tisc_pins.sv
`timescale 1ns/1ps
module tisc_pins (
    // clock
    input wire logic hclk,
    // pins toward the block
    output logic     ext_clock_in_0,
    output logic     ext_clock_in_1,
    output logic     parity_err_n,
    output logic     system_err_n
);
    // error lines idle high as with their pull-ups; clocks stand low
    initial begin
        ext_clock_in_0 = 1'b0;
        ext_clock_in_1 = 1'b0;
        parity_err_n = 1'b1;
        system_err_n = 1'b1;
    end
    // three cycles low so the synchroniser is sure to see the assertion
    task automatic err(input bit sys);
        @(posedge hclk);
        if (sys) system_err_n <= 1'b0;
        else parity_err_n <= 1'b0;
        repeat (3) @(posedge hclk);
        parity_err_n <= 1'b1;
        system_err_n <= 1'b1;
    endtask : err
    // slow external clock for counter 0 or 1; phases span cycles, an async pin is never this kind
    task automatic clk(input bit ch, input int n);
        repeat (n) begin
            @(posedge hclk);
            if (ch) ext_clock_in_1 <= 1'b1;
            else ext_clock_in_0 <= 1'b1;
            repeat (3) @(posedge hclk);
            ext_clock_in_0 <= 1'b0;
            ext_clock_in_1 <= 1'b0;
            repeat (2) @(posedge hclk);
        end
    endtask : clk
endmodule : tisc_pins

// ===== testbench/tisc_top_test.sv
`timescale 1ns/1ps
`include "tisc_map.svh"
module tisc_top_test;
    import tisc_pkg::*;
    localparam logic [11:0] A_EN = {`TISC_IDX_IRQ_CTRL, 2'h0};
    localparam logic [11:0] A_MK = {`TISC_IDX_MASK, 2'h0};
    localparam logic [11:0] A_ST = {`TISC_IDX_STATUS, 2'h0};
    localparam logic [11:0] A_CC = {`TISC_IDX_CLK_CTRL, 2'h0};
    localparam logic [11:0] A_C0 = {`TISC_IDX_CNT0, 2'h0};
    localparam logic [11:0] A_CMD = {`TISC_IDX_CMD, 2'h0};
    logic        hclk, hresetn, hsel, hwrite;
    logic [11:0] haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata;
    logic        hreadyout, irq, hresp;
    logic        e0, e1, perr_n, serr_n;
    logic [2:0]  counter_out;
    int          errors, checks;

    tisc_top #(.DIV(2)) tisc_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ext_clock_in_0(e0), .ext_clock_in_1(e1),
        .parity_err_n(perr_n), .system_err_n(serr_n), .counter_out(counter_out), .irq(irq));
    tisc_pins tisc_pins_i (.hclk(hclk), .ext_clock_in_0(e0), .ext_clock_in_1(e1),
        .parity_err_n(perr_n), .system_err_n(serr_n));

    always #25 hclk = ~hclk;

    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
        end
    endtask : check
    // single transfer; waits on hready in each phase, the watchdog cuts a hang
    task automatic bus(input bit w, input logic [11:0] a, input logic [7:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (!hreadyout);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge hclk); while (!hreadyout);
        r = hrdata;
    endtask : bus
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        logic [31:0] r;
        bus(1'b0, a, 8'h00, r);
        check($sformatf("reg %h", a), r, {24'h0, e});
        check("hresp", {31'h0, hresp}, 32'h0);
    endtask : rd
    // irq is registered behind the status, so let two edges pass
    task automatic irq_is(input logic e);
        repeat (2) @(posedge hclk);
        check("irq", irq, e);
    endtask : irq_is
    task automatic summarize();
        if (errors == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : summarize

    // cut a hang; the tests take well under a thousand cycles
    initial begin
        repeat (5000) @(posedge hclk);
        errors++;
        summarize();
    end

    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 12'h000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        errors = 0;
        checks = 0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        check("reset outputs", {hreadyout, irq, counter_out}, 32'h10);
        rd(A_ST, 8'h00);
        rd(A_CC, 8'h00);
        rd(12'h200, 8'h00);
        // error lines flag while masked and polled
        tisc_pins_i.err(1'b0);
        tisc_pins_i.err(1'b1);
        repeat (8) @(posedge hclk);
        rd(A_ST, 8'h18);
        irq_is(1'b0);
        wr(A_MK, 8'h18);
        wr(A_EN, 8'h10);
        irq_is(1'b1);
        tisc_pins_i.err(1'b0);
        tisc_pins_i.err(1'b1);
        repeat (8) @(posedge hclk);
        wr(A_EN, 8'h11);
        irq_is(1'b0);
        wr(A_ST, 8'h10);
        rd(A_ST, 8'h08);
        wr(A_ST, 8'h00);
        rd(A_ST, 8'h08);
        wr(A_ST, 8'h08);
        rd(A_ST, 8'h00);
        wr(A_EN, 8'h10);
        wr(A_MK, 8'h07);
        irq_is(1'b0);
        // reserved control bits written zero; gate 0 held low at first
        wr(A_CC, 8'hD4);
        rd(A_CC, 8'hD4);
        for (int i = 0; i < 3; i++) begin
            wr(A_CMD, {i[1:0], 6'h30});
            wr(A_C0 + 12'(4 * i), 8'h03);
            wr(A_C0 + 12'(4 * i), 8'h00);
        end
        tisc_pins_i.clk(1'b1, 6);
        repeat (10) @(posedge hclk);
        rd(A_ST, 8'h06);
        // counter 0 is loaded but gated off: both bytes of its count read back
        rd(A_C0, 8'h03);
        rd(A_C0, 8'h00);
        wr(A_CC, 8'hF4);
        repeat (30) @(posedge hclk);
        rd(A_ST, 8'h07);
        check("out", counter_out, 3'h7);
        irq_is(1'b1);
        // outputs stay high yet cleared flags must not come back
        wr(A_ST, 8'h05);
        rd(A_ST, 8'h02);
        wr(A_ST, 8'h02);
        rd(A_ST, 8'h00);
        // chained with counter 1 gated off: counter 2 must starve
        wr(A_CC, 8'h88);
        wr(A_CMD, 8'h74); // short count is allowed
        wr(A_C0 + 12'h004, 8'h02);
        wr(A_C0 + 12'h004, 8'h00);
        wr(A_CMD, 8'hB0);
        wr(A_C0 + 12'h008, 8'h02);
        wr(A_C0 + 12'h008, 8'h00);
        // counter 0 rearmed on its external clock, which is still idle
        wr(A_CMD, 8'h30);
        wr(A_C0, 8'h03);
        wr(A_C0, 8'h00);
        repeat (40) @(posedge hclk);
        rd(A_ST, 8'h00);
        wr(A_CC, 8'hE8);
        tisc_pins_i.clk(1'b0, 5);
        repeat (40) @(posedge hclk);
        rd(A_ST, 8'h07);
        summarize();
    end
endmodule : tisc_top_test
